/* File: dv/rxs_host_model.sv */
// Host model for the receiver status bank register port.
// Assumes the bench compares read data against exp_q one edge after each read.
`timescale 1ns/1ps
module rxs_host_model (
   // Clock
   input  wire logic                       mclk,
   // Register port
   output logic [rxs_pkg::ADDR_W-1:0] reg_addr,
   output logic                       reg_rd,
   output logic                       reg_wr,
   output logic [rxs_pkg::DATA_W-1:0] reg_wdata
);
   logic [7:0] exp_q[$];
   initial begin
      reg_addr  = 7'h00;
      reg_rd    = 1'b0;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
   end
   // Released fields show the inverse so stale values never look valid
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
   endtask : rd
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask : wr
endmodule : rxs_host_model

/* File: dv/rxs_status_regs_tb.sv */
// Self-checking bench for the receiver status register bank.
// Assumes the host model drives the register port; levels settle in one edge.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module rxs_status_regs_tb;
   localparam logic [6:0] AF = rxs_pkg::ADDR_FAULT;
   localparam logic [6:0] AM = rxs_pkg::ADDR_FAULT_MASK;
   logic mclk = 0, rst_n = 0, reg_rd, reg_wr, rx_irq, rd_q = 0;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, e;
   logic [14:0] rate_ratio_value = 0, r;
   logic [15:0] burst_info_word = 0, burst_length_word = 0, chb_info_word = 0;
   logic nonaudio_detected = 0, subframe_nonaudio = 0, received_validity_flag = 0;
   logic emphasis_flag = 0, cs_nonaudio_flag = 0, preamble_nonaudio_flag = 0;
   logic chstat_checksum_fault = 0, input_absent_flag = 0, coding_error = 0;
   logic pll_locked = 0;
   logic [4:0] nonaudio_type = 0;
   int fails = 0, n_tests = 0;
   rxs_status_regs i_dut (.mclk, .rst_n, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
      .reg_rdata, .rate_ratio_value, .nonaudio_detected, .subframe_nonaudio,
      .burst_info_word, .burst_length_word, .chb_info_word, .received_validity_flag,
      .emphasis_flag, .cs_nonaudio_flag, .nonaudio_type, .preamble_nonaudio_flag,
      .chstat_checksum_fault, .input_absent_flag, .coding_error, .pll_locked, .rx_irq);
   rxs_host_model i_host (.mclk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);
   initial begin
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) rd_q <= reg_rd;
   always @(negedge mclk) begin
      if (rd_q && rst_n) begin
         e = i_host.exp_q.pop_front();
         `CHK(reg_rdata, e)
      end
   end
   function automatic logic [7:0] lv();
      return {received_validity_flag, emphasis_flag, cs_nonaudio_flag,
              preamble_nonaudio_flag, 1'b0, input_absent_flag, 1'b0, pll_locked};
   endfunction : lv
   task automatic irq_is(input int n, input logic v);
      repeat (n) @(posedge mclk);
      #1;
      `CHK(rx_irq, v)
   endtask : irq_is
   task automatic hit();
      @(posedge mclk);
      {chstat_checksum_fault, coding_error} <= 2'b11;
      @(posedge mclk);
      {chstat_checksum_fault, coding_error} <= 2'b00;
   endtask : hit
   task automatic end_sim();
      if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      end_sim();
   end
   initial begin
      void'($urandom(32'h915f));
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      i_host.rd(AF, 8'h00);
      i_host.rd(rxs_pkg::ADDR_RATIO_LOW, 8'h00);
      i_host.rd(7'h11, 8'h00);
      r = 15'($urandom);
      rate_ratio_value <= r;
      i_host.rd(rxs_pkg::ADDR_RATIO_HIGH, {1'b0, r[14:8]});
      rate_ratio_value <= ~r;
      i_host.rd(rxs_pkg::ADDR_RATIO_LOW, r[7:0]);
      {burst_info_word, burst_length_word, chb_info_word} <= 48'({$urandom, $urandom});
      i_host.rd(rxs_pkg::ADDR_INFO_HIGH, 8'h00);
      i_host.rd(rxs_pkg::ADDR_LENGTH_HIGH, 8'h00);
      nonaudio_detected <= 1'b1;
      i_host.rd(rxs_pkg::ADDR_INFO_HIGH, burst_info_word[15:8]);
      i_host.rd(rxs_pkg::ADDR_INFO_LOW, burst_info_word[7:0]);
      i_host.rd(rxs_pkg::ADDR_LENGTH_HIGH, burst_length_word[15:8]);
      i_host.rd(rxs_pkg::ADDR_LENGTH_LOW, burst_length_word[7:0]);
      subframe_nonaudio <= 1'b1;
      i_host.rd(rxs_pkg::ADDR_LENGTH_HIGH, chb_info_word[15:8]);
      i_host.rd(rxs_pkg::ADDR_LENGTH_LOW, chb_info_word[7:0]);
      for (int i = 0; i < 2; i++) begin
         r = 15'($urandom);
         {received_validity_flag, emphasis_flag, cs_nonaudio_flag, preamble_nonaudio_flag,
          input_absent_flag, pll_locked} <= (i == 0) ? r[5:0] : ~r[5:0];
         @(posedge mclk);
         i_host.rd(AF, lv());
         i_host.rd(AF, lv());
      end
      hit();
      i_host.rd(AF, lv() | 8'h0a);
      i_host.rd(AF, lv());
      i_host.wr(AF, 8'hff);
      i_host.rd(AF, lv());
      i_host.wr(AM, 8'hf5);
      i_host.rd(AM, 8'hf5);
      hit();
      irq_is(3, 1'b0);
      i_host.rd(AF, lv() | 8'h0a);
      i_host.wr(AM, 8'h02);
      hit();
      irq_is(2, 1'b1);
      i_host.rd(AF, lv() | 8'h0a);
      irq_is(1, 1'b0);
      i_host.wr(AM, 8'h01);
      pll_locked <= ~pll_locked;
      irq_is(3, 1'b1);
      i_host.rd(AF, lv());
      irq_is(1, 1'b0);
      irq_is(5, 1'b0);
      i_host.wr(AM, 8'h20);
      cs_nonaudio_flag <= 1'b1;
      @(posedge mclk);
      i_host.rd(AF, lv());
      irq_is(1, 1'b0);
      @(posedge mclk);
      nonaudio_type <= nonaudio_type + 5'h01;
      irq_is(3, 1'b1);
      i_host.rd(AF, lv());
      irq_is(1, 1'b0);
      end_sim();
   end
endmodule : rxs_status_regs_tb

/* File: verilog/rxs_pkg.sv */
// Package for the receiver status register bank: addresses, bit positions,
// reset values and widths.
// Assumes a 7-bit register address from the serial control port decoder.
package rxs_pkg;
   localparam int unsigned ADDR_W      = 7;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned RATIO_W     = 15;
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned NA_TYPE_W   = 5;

   localparam logic [6:0] ADDR_RATIO_HIGH  = 7'h12;
   localparam logic [6:0] ADDR_RATIO_LOW   = 7'h13;
   localparam logic [6:0] ADDR_INFO_HIGH   = 7'h14;
   localparam logic [6:0] ADDR_INFO_LOW    = 7'h15;
   localparam logic [6:0] ADDR_LENGTH_HIGH = 7'h16;
   localparam logic [6:0] ADDR_LENGTH_LOW  = 7'h17;
   localparam logic [6:0] ADDR_FAULT       = 7'h18;
   localparam logic [6:0] ADDR_FAULT_MASK  = 7'h19;

   // Bit positions inside the fault and mask registers
   localparam int unsigned BIT_VALIDITY = 7;
   localparam int unsigned BIT_EMPH     = 6;
   localparam int unsigned BIT_NONAUDIO = 5;
   localparam int unsigned BIT_PREAMBLE = 4;
   localparam int unsigned BIT_CHECKSUM = 3;
   localparam int unsigned BIT_ABSENT   = 2;
   localparam int unsigned BIT_CODING   = 1;
   localparam int unsigned BIT_LOCK     = 0;

   // Bits that latch until read; the others follow a condition
   localparam logic [7:0] LATCHED_BITS = 8'h0a;

   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [7:0]  MASK_RST  = 8'h00;
   localparam logic [7:0]  DATA_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
endpackage : rxs_pkg

/* File: verilog/rxs_status_regs.sv */
// Receiver status register bank: sample rate ratio, burst preamble words,
// receiver fault flags with their interrupt mask, and the interrupt request.
// Assumes a serial control port decoder presenting one-cycle read and write
// strobes with a 7-bit address; all inputs are synchronous to mclk.
//
// Overview of operation
// R1: 15-bit ratio split over high and low
// R2: First preamble word, else zeros
// R3: Second preamble word, else zeros
// R4: Subframe mode shows channel B word
// R5: Bit 7 follows the stream validity bit
// R6: Bit 6 emphasis, event only on change
// R7: Bit 5 nonaudio, event on change/type
// R8: Bit 4 preamble detect, event on change
// R9: Bit 3 checksum fault latched until read
// R10: Bit 2 stream absent, event on change
// R11: Bit 1 coding/parity error latched until read
// R12: Bit 0 lock state, event on change
// R13: Fault register ignores host writes
// R14: Mask bit 1 lets flag interrupt
// R15: Interrupt while unmasked event pending; read acknowledges
// R16: High-byte read snapshots matching low byte
`timescale 1ns/1ps
module rxs_status_regs (
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   // Register port
   input  wire logic [rxs_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic                          reg_rd,
   input  wire logic                          reg_wr,
   input  wire logic [rxs_pkg::DATA_W-1:0]    reg_wdata,
   output logic      [rxs_pkg::DATA_W-1:0]    reg_rdata,
   // Measured values
   input  wire logic [rxs_pkg::RATIO_W-1:0]   rate_ratio_value,
   input  wire logic                          nonaudio_detected,
   input  wire logic                          subframe_nonaudio,
   input  wire logic [rxs_pkg::WORD_W-1:0]    burst_info_word,
   input  wire logic [rxs_pkg::WORD_W-1:0]    burst_length_word,
   input  wire logic [rxs_pkg::WORD_W-1:0]    chb_info_word,
   // Receiver conditions
   input  wire logic                          received_validity_flag,
   input  wire logic                          emphasis_flag,
   input  wire logic                          cs_nonaudio_flag,
   input  wire logic [rxs_pkg::NA_TYPE_W-1:0] nonaudio_type,
   input  wire logic                          preamble_nonaudio_flag,
   input  wire logic                          chstat_checksum_fault,
   input  wire logic                          input_absent_flag,
   input  wire logic                          coding_error,
   input  wire logic                          pll_locked,
   // Interrupt
   output logic                               rx_irq
);

   logic [7:0]                      flags_q;
   logic [7:0]                      pend_q;
   logic [7:0]                      mask_q;
   logic [7:0]                      cond_d;
   logic [7:0]                      evt_d;
   logic [rxs_pkg::NA_TYPE_W-1:0]   type_q;
   logic [7:0]                      ratio_snap_q;
   logic [7:0]                      info_snap_q;
   logic [7:0]                      length_snap_q;
   logic [rxs_pkg::WORD_W-1:0]      info_live;
   logic [rxs_pkg::WORD_W-1:0]      length_live;
   logic [rxs_pkg::WORD_W-1:0]      ratio_live;
   logic                            fault_rd;
   logic                            type_chg;

   assign fault_rd = reg_rd && (reg_addr == rxs_pkg::ADDR_FAULT);
   assign type_chg = cs_nonaudio_flag && (nonaudio_type != type_q);

   // Preamble words collapse to zero outside compressed data
   assign info_live   = nonaudio_detected ? burst_info_word : rxs_pkg::WORD_ZERO; // R2
   assign length_live = !nonaudio_detected ? rxs_pkg::WORD_ZERO :                 // R3
                        (subframe_nonaudio ? chb_info_word : burst_length_word);  // R4
   assign ratio_live  = {1'b0, rate_ratio_value};                                 // R1

   // Present condition for each flag; latched bits carry their event pulse
   always_comb begin
      cond_d                         = rxs_pkg::FLAGS_RST;
      cond_d[rxs_pkg::BIT_VALIDITY]  = received_validity_flag;   // R5
      cond_d[rxs_pkg::BIT_EMPH]      = emphasis_flag;            // R6
      cond_d[rxs_pkg::BIT_NONAUDIO]  = cs_nonaudio_flag;         // R7
      cond_d[rxs_pkg::BIT_PREAMBLE]  = preamble_nonaudio_flag;   // R8
      cond_d[rxs_pkg::BIT_CHECKSUM]  = chstat_checksum_fault;    // R9
      cond_d[rxs_pkg::BIT_ABSENT]    = input_absent_flag;        // R10
      cond_d[rxs_pkg::BIT_CODING]    = coding_error;             // R11
      cond_d[rxs_pkg::BIT_LOCK]      = pll_locked;               // R12
   end

   // Per-bit flag and pending event
   for (genvar i = 0; i < 8; i++) begin : g_flag
      if (rxs_pkg::LATCHED_BITS[i]) begin : g_latch
         assign evt_d[i] = cond_d[i];
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               flags_q[i] <= 1'b0;
            end else if (cond_d[i]) begin
               flags_q[i] <= 1'b1;                                // R9 R11
            end else if (fault_rd) begin
               flags_q[i] <= 1'b0;                                // R9 R11
            end
         end
      end else begin : g_level
         // Type change while cs_nonaudio_flag is set counts as a fresh nonaudio event
         if (i == rxs_pkg::BIT_NONAUDIO) begin : g_na
            assign evt_d[i] = (cond_d[i] != flags_q[i]) || type_chg;   // R7
         end else begin : g_plain
            assign evt_d[i] = (cond_d[i] != flags_q[i]);               // R6 R8 R10 R12
         end
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               flags_q[i] <= 1'b0;
            end else begin
               flags_q[i] <= cond_d[i];                           // R5 R12
            end
         end
      end
      // New event beats the acknowledge of a read in the same cycle
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            pend_q[i] <= 1'b0;
         end else if (evt_d[i]) begin
            pend_q[i] <= 1'b1;
         end else if (fault_rd) begin
            pend_q[i] <= 1'b0;                                    // R15
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         type_q <= '0;
      end else begin
         type_q <= nonaudio_type;
      end
   end

   // Only the mask is writable; the fault flags take no write path
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= rxs_pkg::MASK_RST;
      end else if (reg_wr && (reg_addr == rxs_pkg::ADDR_FAULT_MASK)) begin
         mask_q <= reg_wdata;                                     // R14 R13
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_irq <= 1'b0;
      end else begin
         rx_irq <= |(pend_q & mask_q);                            // R14 R15
      end
   end

   // Low bytes frozen when the high byte is read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ratio_snap_q  <= rxs_pkg::DATA_ZERO;
         info_snap_q   <= rxs_pkg::DATA_ZERO;
         length_snap_q <= rxs_pkg::DATA_ZERO;
      end else if (reg_rd) begin
         if (reg_addr == rxs_pkg::ADDR_RATIO_HIGH) begin
            ratio_snap_q <= ratio_live[7:0];                      // R16
         end
         if (reg_addr == rxs_pkg::ADDR_INFO_HIGH) begin
            info_snap_q <= info_live[7:0];                        // R16
         end
         if (reg_addr == rxs_pkg::ADDR_LENGTH_HIGH) begin
            length_snap_q <= length_live[7:0];                    // R16
         end
      end
   end

   // Read data; unmapped addresses read zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= rxs_pkg::DATA_ZERO;
      end else if (reg_rd) begin
         case (reg_addr)
            rxs_pkg::ADDR_RATIO_HIGH:  reg_rdata <= ratio_live[15:8];   // R1
            rxs_pkg::ADDR_RATIO_LOW:   reg_rdata <= ratio_snap_q;       // R1
            rxs_pkg::ADDR_INFO_HIGH:   reg_rdata <= info_live[15:8];    // R2
            rxs_pkg::ADDR_INFO_LOW:    reg_rdata <= info_snap_q;        // R2
            rxs_pkg::ADDR_LENGTH_HIGH: reg_rdata <= length_live[15:8];  // R3 R4
            rxs_pkg::ADDR_LENGTH_LOW:  reg_rdata <= length_snap_q;      // R3 R4
            rxs_pkg::ADDR_FAULT:       reg_rdata <= flags_q;
            rxs_pkg::ADDR_FAULT_MASK:  reg_rdata <= mask_q;
            default:                   reg_rdata <= rxs_pkg::DATA_ZERO;
         endcase
      end
   end

   a_ratio_high: assert property (@(posedge mclk) disable iff (!rst_n) // R1
      reg_rd && reg_addr == rxs_pkg::ADDR_RATIO_HIGH |=>
      reg_rdata == {1'b0, $past(rate_ratio_value[14:8])})
      else $error("ratio high byte wrong");

   // Host reads every other cycle, so the pair is checked with one idle cycle between
   a_ratio_pair: assert property (@(posedge mclk) disable iff (!rst_n) // R16
      reg_rd && reg_addr == rxs_pkg::ADDR_RATIO_HIGH ##1 !reg_rd ##1
      reg_rd && reg_addr == rxs_pkg::ADDR_RATIO_LOW |=>
      reg_rdata == $past(rate_ratio_value[7:0], 3))
      else $error("ratio low byte not coherent");

   a_info_zero: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      reg_rd && reg_addr == rxs_pkg::ADDR_INFO_HIGH && !nonaudio_detected |=>
      reg_rdata == rxs_pkg::DATA_ZERO)
      else $error("preamble info not zero in audio");

   a_chb_select: assert property (@(posedge mclk) disable iff (!rst_n) // R4
      reg_rd && reg_addr == rxs_pkg::ADDR_LENGTH_HIGH && nonaudio_detected
      && subframe_nonaudio |=> reg_rdata == $past(chb_info_word[15:8]))
      else $error("channel B word not shown");

   a_length_word: assert property (@(posedge mclk) disable iff (!rst_n) // R3
      reg_rd && reg_addr == rxs_pkg::ADDR_LENGTH_HIGH && nonaudio_detected
      && !subframe_nonaudio |=> reg_rdata == $past(burst_length_word[15:8]))
      else $error("second preamble word wrong");

   a_checksum_hold: assert property (@(posedge mclk) disable iff (!rst_n) // R9
      chstat_checksum_fault ##1 !fault_rd [*3] |=> flags_q[rxs_pkg::BIT_CHECKSUM])
      else $error("checksum flag lost before read");

   a_coding_clear: assert property (@(posedge mclk) disable iff (!rst_n) // R11
      fault_rd && !coding_error |=> !flags_q[rxs_pkg::BIT_CODING])
      else $error("coding flag not cleared by read");

   a_write_ignored: assert property (@(posedge mclk) disable iff (!rst_n) // R13
      reg_wr && reg_addr == rxs_pkg::ADDR_FAULT && !reg_rd
      && !chstat_checksum_fault && !coding_error |=>
      $stable(flags_q[rxs_pkg::BIT_CHECKSUM]) && $stable(flags_q[rxs_pkg::BIT_CODING]))
      else $error("write changed fault flags");

   a_lock_follow: assert property (@(posedge mclk) disable iff (!rst_n) // R12
      $changed(pll_locked) |=> flags_q[rxs_pkg::BIT_LOCK] == $past(pll_locked)
      ##1 pend_q[rxs_pkg::BIT_LOCK] || $past(fault_rd))
      else $error("lock change not recorded");

   a_valid_follow: assert property (@(posedge mclk) disable iff (!rst_n) // R5
      1'b1 |=> flags_q[rxs_pkg::BIT_VALIDITY] == $past(received_validity_flag))
      else $error("validity bit not tracked");

   a_irq_masked: assert property (@(posedge mclk) disable iff (!rst_n) // R14
      mask_q == rxs_pkg::MASK_RST [*2] |-> !rx_irq)
      else $error("interrupt with all masked");

   a_irq_pending: assert property (@(posedge mclk) disable iff (!rst_n) // R15
      |(pend_q & mask_q) |=> rx_irq)
      else $error("pending event gave no interrupt");

   a_na_type: assert property (@(posedge mclk) disable iff (!rst_n) // R7
      type_chg |=> pend_q[rxs_pkg::BIT_NONAUDIO])
      else $error("nonaudio type change gave no event");

   a_info_word: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      reg_rd && reg_addr == rxs_pkg::ADDR_INFO_HIGH && nonaudio_detected |=>
      reg_rdata == $past(burst_info_word[15:8]))
      else $error("first preamble word wrong");

   a_info_pair: assert property (@(posedge mclk) disable iff (!rst_n) // R16
      reg_rd && reg_addr == rxs_pkg::ADDR_INFO_HIGH && nonaudio_detected ##1 !reg_rd ##1
      reg_rd && reg_addr == rxs_pkg::ADDR_INFO_LOW |=>
      reg_rdata == $past(burst_info_word[7:0], 3))
      else $error("preamble low byte not coherent");

   a_length_zero: assert property (@(posedge mclk) disable iff (!rst_n) // R3
      reg_rd && reg_addr == rxs_pkg::ADDR_LENGTH_HIGH && !nonaudio_detected |=>
      reg_rdata == rxs_pkg::DATA_ZERO)
      else $error("second preamble word not zero in audio");

   a_emph_event: assert property (@(posedge mclk) disable iff (!rst_n) // R6
      $changed(emphasis_flag) |=> pend_q[rxs_pkg::BIT_EMPH]
      && flags_q[rxs_pkg::BIT_EMPH] == $past(emphasis_flag))
      else $error("emphasis change not recorded");

   a_emph_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // R6
      fault_rd && emphasis_flag && flags_q[rxs_pkg::BIT_EMPH] |=>
      flags_q[rxs_pkg::BIT_EMPH] && !pend_q[rxs_pkg::BIT_EMPH])
      else $error("emphasis flag dropped or re-raised after read");

   a_na_event: assert property (@(posedge mclk) disable iff (!rst_n) // R7
      $changed(cs_nonaudio_flag) |=> pend_q[rxs_pkg::BIT_NONAUDIO])
      else $error("nonaudio change gave no event");

   a_pre_event: assert property (@(posedge mclk) disable iff (!rst_n) // R8
      $changed(preamble_nonaudio_flag) |=> pend_q[rxs_pkg::BIT_PREAMBLE])
      else $error("preamble detect change gave no event");

   a_absent_quiet: assert property (@(posedge mclk) disable iff (!rst_n) // R10
      fault_rd && input_absent_flag && flags_q[rxs_pkg::BIT_ABSENT] |=>
      flags_q[rxs_pkg::BIT_ABSENT] && !pend_q[rxs_pkg::BIT_ABSENT])
      else $error("absent flag dropped or re-raised after read");

   a_checksum_set: assert property (@(posedge mclk) disable iff (!rst_n) // R9
      chstat_checksum_fault |=> flags_q[rxs_pkg::BIT_CHECKSUM]
      && pend_q[rxs_pkg::BIT_CHECKSUM])
      else $error("checksum fault not latched");

   a_coding_set: assert property (@(posedge mclk) disable iff (!rst_n) // R11
      coding_error |=> flags_q[rxs_pkg::BIT_CODING] && pend_q[rxs_pkg::BIT_CODING])
      else $error("coding error not latched");

   a_mask_write: assert property (@(posedge mclk) disable iff (!rst_n) // R14
      reg_wr && reg_addr == rxs_pkg::ADDR_FAULT_MASK |=> mask_q == $past(reg_wdata))
      else $error("mask write lost");

   // Without a fresh event the request must fall two edges after the read
   a_irq_ack: assert property (@(posedge mclk) disable iff (!rst_n) // R15
      fault_rd && evt_d == rxs_pkg::FLAGS_RST |-> ##2 !rx_irq)
      else $error("interrupt not acknowledged by read");

   a_lock_read: assert property (@(posedge mclk) disable iff (!rst_n) // R12
      fault_rd && pll_locked == flags_q[rxs_pkg::BIT_LOCK] |=>
      !pend_q[rxs_pkg::BIT_LOCK])
      else $error("steady lock raised an event after read");

endmodule : rxs_status_regs
